/* File: src/adc_hpf_route_invert.sv */
/*
 * ADC post-processing: high pass filter, polarity inversion and slot routing,
 * with an AXI4-Lite register slave. Assumes in-domain sample strobes from the
 * decimators and a serializer that takes one stereo pair per output strobe.
 */
// Summary of operation
// - Filter both channels when enable is one; bypass when zero; enable resets to one.
// - Two-bit cut-off field at bits 6:5 resets to hi-fi, 4 Hz at 48 kHz.
// - Field value 01 selects voice mode 1, 127 Hz at 16 kHz.
// - Field value 10 selects voice mode 2, 130 Hz at 8 kHz.
// - Field value 11 selects voice mode 3, 267 Hz at 8 kHz.
// - Coefficients are fixed per sample, so cut-off scales with sample rate.
// - Bit 15 picks left slot source: zero left ADC, one right; resets zero.
// - Bit 14 picks right slot source: zero left ADC, one right; resets one.
// - Bit 1 of filter control inverts left ADC output; resets clear.
// - Bit 0 of filter control inverts right ADC output; resets clear.
`timescale 1ns/1ps
module adc_hpf_route_invert #(
   parameter int unsigned WIDTH = hpf_pkg::SAMPLE_WIDTH
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic [31:0]             s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [31:0]             s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    sample_strobe,
   input  wire logic signed [WIDTH-1:0] adc_left,
   input  wire logic signed [WIDTH-1:0] adc_right,
   output logic                         slot_strobe,
   output logic signed [WIDTH-1:0]      slot_left,
   output logic signed [WIDTH-1:0]      slot_right
);
   logic        left_slot_source;
   logic        right_slot_source;
   logic        highpass_enable;
   logic [1:0]  cutoff_select;
   logic        left_polarity_invert;
   logic        right_polarity_invert;

   logic        aw_held;
   logic        w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        write_go;
   logic        write_hit;
   logic        source_write;
   logic        control_write;

   logic                    filter_strobe;
   logic                    invert_strobe;
   logic signed [WIDTH-1:0] filt_left;
   logic signed [WIDTH-1:0] filt_right;
   logic signed [WIDTH-1:0] inv_left;
   logic signed [WIDTH-1:0] inv_right;
   logic [31:0]             next_rdata;
   logic                    read_hit;

   // Byte address is four times the printed index.
   function automatic logic [31:0] byte_addr(input logic [hpf_pkg::ADDR_WIDTH-1:0] index);
      byte_addr = {22'h00_0000, index, 2'b00};
   endfunction

   function automatic logic signed [WIDTH-1:0] negate_sat(input logic signed [WIDTH-1:0] v);
      if (v == {1'b1, {(WIDTH-1){1'b0}}}) begin
         negate_sat = {1'b0, {(WIDTH-1){1'b1}}};
      end else begin
         negate_sat = -v;
      end
   endfunction

   function automatic logic [31:0] source_word(input logic l, input logic r);
      source_word = '0;
      source_word[hpf_pkg::LEFT_SLOT_SOURCE_BIT]  = l;
      source_word[hpf_pkg::RIGHT_SLOT_SOURCE_BIT] = r;
   endfunction

   // Write channel: address and data are taken in either order, then answered together.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign write_go      = aw_held && w_held && !s_axi_bvalid;
   assign source_write  = write_go && (aw_addr == byte_addr(hpf_pkg::SOURCE_INDEX));
   assign control_write = write_go && (aw_addr == byte_addr(hpf_pkg::CONTROL_INDEX));

   always_ff @(posedge clk) begin
      if (srst) begin
         aw_held <= 1'b0;
         aw_addr <= 32'h0000_0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (write_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (write_go) begin
         w_held <= 1'b0;
      end
   end

   always_comb begin
      write_hit = (aw_addr == byte_addr(hpf_pkg::SOURCE_INDEX))
               || (aw_addr == byte_addr(hpf_pkg::CONTROL_INDEX));
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= hpf_pkg::RESP_OKAY;
      end else if (write_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= write_hit ? hpf_pkg::RESP_OKAY : hpf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Slot source register; only the upper byte lane holds live bits.
   always_ff @(posedge clk) begin
      if (srst) begin
         left_slot_source <= hpf_pkg::LEFT_SLOT_SOURCE_RESET;
      end else if (source_write && w_strb[1]) begin
         left_slot_source <= w_data[hpf_pkg::LEFT_SLOT_SOURCE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         right_slot_source <= hpf_pkg::RIGHT_SLOT_SOURCE_RESET;
      end else if (source_write && w_strb[1]) begin
         right_slot_source <= w_data[hpf_pkg::RIGHT_SLOT_SOURCE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         highpass_enable <= hpf_pkg::HIGHPASS_ENABLE_RESET;
      end else if (control_write && w_strb[1]) begin
         highpass_enable <= w_data[hpf_pkg::HIGHPASS_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cutoff_select <= hpf_pkg::CUTOFF_SELECT_RESET;
      end else if (control_write && w_strb[0]) begin
         cutoff_select <= w_data[hpf_pkg::CUTOFF_SELECT_MSB:hpf_pkg::CUTOFF_SELECT_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         left_polarity_invert <= hpf_pkg::POLARITY_INVERT_RESET;
      end else if (control_write && w_strb[0]) begin
         left_polarity_invert <= w_data[hpf_pkg::LEFT_POLARITY_INVERT_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         right_polarity_invert <= hpf_pkg::POLARITY_INVERT_RESET;
      end else if (control_write && w_strb[0]) begin
         right_polarity_invert <= w_data[hpf_pkg::RIGHT_POLARITY_INVERT_BIT];
      end
   end

   // Read channel; the status word shows the last output pair signs, left in bit 0 and right in bit 1.
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      next_rdata = 32'h0000_0000;
      read_hit   = 1'b1;
      if (s_axi_araddr == byte_addr(hpf_pkg::SOURCE_INDEX)) begin
         next_rdata = source_word(left_slot_source, right_slot_source);
      end else if (s_axi_araddr == byte_addr(hpf_pkg::CONTROL_INDEX)) begin
         next_rdata[hpf_pkg::HIGHPASS_ENABLE_BIT] = highpass_enable;
         next_rdata[hpf_pkg::CUTOFF_SELECT_MSB:hpf_pkg::CUTOFF_SELECT_LSB] = cutoff_select;
         next_rdata[hpf_pkg::LEFT_POLARITY_INVERT_BIT]  = left_polarity_invert;
         next_rdata[hpf_pkg::RIGHT_POLARITY_INVERT_BIT] = right_polarity_invert;
      end else if (s_axi_araddr == byte_addr(hpf_pkg::STATUS_INDEX)) begin
         next_rdata[0] = slot_left[WIDTH-1];
         next_rdata[1] = slot_right[WIDTH-1];
      end else begin
         read_hit = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= hpf_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= read_hit ? hpf_pkg::RESP_OKAY : hpf_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Stage one: the filter on each channel.
   hpf_channel #(
      .WIDTH (WIDTH)
   ) left_filter (
      .clk        (clk),
      .srst       (srst),
      .strobe     (sample_strobe),
      .enable     (highpass_enable),
      .cutoff     (cutoff_select),
      .sample_in  (adc_left),
      .sample_out (filt_left)
   );

   hpf_channel #(
      .WIDTH (WIDTH)
   ) right_filter (
      .clk        (clk),
      .srst       (srst),
      .strobe     (sample_strobe),
      .enable     (highpass_enable),
      .cutoff     (cutoff_select),
      .sample_in  (adc_right),
      .sample_out (filt_right)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         filter_strobe <= 1'b0;
      end else begin
         filter_strobe <= sample_strobe;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         invert_strobe <= 1'b0;
      end else begin
         invert_strobe <= filter_strobe;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         slot_strobe <= 1'b0;
      end else begin
         slot_strobe <= invert_strobe;
      end
   end

   // Stage two: optional inversion after the filter.
   always_ff @(posedge clk) begin
      if (srst) begin
         inv_left <= '0;
      end else if (filter_strobe) begin
         inv_left <= left_polarity_invert ? negate_sat(filt_left) : filt_left;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         inv_right <= '0;
      end else if (filter_strobe) begin
         inv_right <= right_polarity_invert ? negate_sat(filt_right) : filt_right;
      end
   end

   // Stage three: the crossbar, sampled only on a strobe so a change never splits a pair.
   always_ff @(posedge clk) begin
      if (srst) begin
         slot_left <= '0;
      end else if (invert_strobe) begin
         slot_left <= left_slot_source ? inv_right : inv_left;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         slot_right <= '0;
      end else if (invert_strobe) begin
         slot_right <= right_slot_source ? inv_right : inv_left;
      end
   end
endmodule

/* File: src/hpf_pkg.sv */
/*
 * Shared constants for the ADC high pass filter, inversion and slot routing block.
 * Assumes a 40 MHz system clock and a sample strobe from the decimators.
 */
package hpf_pkg;
   localparam int unsigned SAMPLE_WIDTH = 24;
   localparam int unsigned ADDR_WIDTH   = 8;

   // Printed offsets 0x04 and 0x0e are not all multiples of four, so they are indices.
   localparam logic [ADDR_WIDTH-1:0] SOURCE_INDEX  = 8'h04;
   localparam logic [ADDR_WIDTH-1:0] CONTROL_INDEX = 8'h0e;
   localparam logic [ADDR_WIDTH-1:0] STATUS_INDEX  = 8'h10;

   localparam int unsigned LEFT_SLOT_SOURCE_BIT      = 15;
   localparam int unsigned RIGHT_SLOT_SOURCE_BIT     = 14;
   localparam int unsigned HIGHPASS_ENABLE_BIT       = 8;
   localparam int unsigned CUTOFF_SELECT_MSB         = 6;
   localparam int unsigned CUTOFF_SELECT_LSB         = 5;
   localparam int unsigned LEFT_POLARITY_INVERT_BIT  = 1;
   localparam int unsigned RIGHT_POLARITY_INVERT_BIT = 0;

   localparam logic       LEFT_SLOT_SOURCE_RESET      = 1'b0;
   localparam logic       RIGHT_SLOT_SOURCE_RESET     = 1'b1;
   localparam logic       HIGHPASS_ENABLE_RESET       = 1'b1;
   localparam logic [1:0] CUTOFF_SELECT_RESET         = 2'b00;
   localparam logic       POLARITY_INVERT_RESET       = 1'b0;

   typedef enum logic [1:0] {
      CUTOFF_HIFI,
      CUTOFF_VOICE1,
      CUTOFF_VOICE2,
      CUTOFF_VOICE3
   } cutoff_type;

   // Pole shift k gives pole 1 - 2^-k; fc is about fs / (2 pi 2^k), so it scales with fs.
   localparam int unsigned SHIFT_HIFI   = 11;
   localparam int unsigned SHIFT_VOICE1 = 5;
   localparam int unsigned SHIFT_VOICE2 = 3;
   localparam int unsigned SHIFT_VOICE3 = 2;
   localparam int unsigned GUARD_BITS   = 12;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: src/hpf_channel.sv */
/*
 * One channel of the first-order DC blocking filter.
 * Assumes samples arrive at most once per clock, marked by a strobe.
 */
`timescale 1ns/1ps
module hpf_channel #(
   parameter int unsigned WIDTH = hpf_pkg::SAMPLE_WIDTH
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    strobe,
   input  wire logic                    enable,
   input  wire logic [1:0]              cutoff,
   input  wire logic signed [WIDTH-1:0] sample_in,
   output logic signed [WIDTH-1:0]      sample_out
);
   localparam int unsigned ACC = WIDTH + hpf_pkg::GUARD_BITS + 2;

   logic signed [ACC-1:0] dc_estimate;
   logic signed [ACC-1:0] input_scaled;
   logic signed [ACC-1:0] error;
   logic signed [ACC-1:0] next_estimate;
   logic signed [ACC-1:0] filtered;
   logic signed [ACC-1:0] pos_limit;
   logic signed [ACC-1:0] neg_limit;

   // Coefficients are fixed per sample, so the cut-off tracks the sample rate.
   function automatic logic signed [ACC-1:0] scale_down(input logic signed [ACC-1:0] value,
                                                        input logic [1:0] sel);
      case (sel)
         2'b00:   scale_down = value >>> hpf_pkg::SHIFT_HIFI;
         2'b01:   scale_down = value >>> hpf_pkg::SHIFT_VOICE1;
         2'b10:   scale_down = value >>> hpf_pkg::SHIFT_VOICE2;
         default: scale_down = value >>> hpf_pkg::SHIFT_VOICE3;
      endcase
   endfunction

   always_comb begin
      input_scaled  = ACC'(sample_in) <<< hpf_pkg::GUARD_BITS;
      error         = input_scaled - dc_estimate;
      next_estimate = dc_estimate + scale_down(error, cutoff);
      filtered      = error >>> hpf_pkg::GUARD_BITS;
      pos_limit     = ACC'({1'b0, {(WIDTH-1){1'b1}}});
      neg_limit     = -pos_limit - ACC'(1);
   end

   // The estimate is held at zero while bypassed, so re-enabling starts from a clean state.
   always_ff @(posedge clk) begin
      if (srst || !enable) begin
         dc_estimate <= '0;
      end else if (strobe) begin
         dc_estimate <= next_estimate;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sample_out <= '0;
      end else if (strobe) begin
         if (!enable) begin
            sample_out <= sample_in;
         end else if (filtered > pos_limit) begin
            sample_out <= pos_limit[WIDTH-1:0];
         end else if (filtered < neg_limit) begin
            sample_out <= neg_limit[WIDTH-1:0];
         end else begin
            sample_out <= filtered[WIDTH-1:0];
         end
      end
   end
endmodule

/* File: sim/adc_hpf_monitor.sv */
/* Port checker for the ADC filter, inversion and slot routing block.
   Assumes it is bound to that block and sees only its ports. */
`timescale 1ns/1ps
module adc_hpf_monitor #(
   parameter int unsigned WIDTH = 24
) (
   input wire logic                    clk,
   input wire logic                    srst,
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_wvalid,
   input wire logic                    s_axi_wready,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic [31:0]             s_axi_araddr,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic [31:0]             s_axi_rdata,
   input wire logic [1:0]              s_axi_rresp,
   input wire logic                    s_axi_rvalid,
   input wire logic                    sample_strobe,
   input wire logic                    slot_strobe,
   input wire logic signed [WIDTH-1:0] slot_left,
   input wire logic signed [WIDTH-1:0] slot_right
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic mapped;
   logic aw_w_taken;
   assign mapped = s_axi_araddr inside {32'h0000_0010, 32'h0000_0038, 32'h0000_0040};
   assign aw_w_taken = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   property p_slot_latency; sample_strobe |-> ##3 slot_strobe; endproperty
   a_slot_latency: assert property (p_slot_latency) else $error("slot strobe late");
   property p_slot_cause; slot_strobe |-> $past(sample_strobe, 3); endproperty
   a_slot_cause: assert property (p_slot_cause) else $error("slot strobe uncaused");
   property p_slot_hold;
      !slot_strobe |-> $stable(slot_left) && $stable(slot_right);
   endproperty
   a_slot_hold: assert property (p_slot_hold) else $error("slot data moved");
   property p_write_answer; aw_w_taken |-> ##2 s_axi_bvalid; endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");
   property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("no read response");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && !mapped |=>
         s_axi_rresp == hpf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
   property p_write_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_write_busy: assert property (p_write_busy) else $error("write taken while busy");
   property p_read_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_read_busy: assert property (p_read_busy) else $error("read taken while busy");
   property p_resp_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_resp_drop: assert property (p_resp_drop) else $error("write response kept");
   c_slot: cover property (slot_strobe);
   c_write: cover property (aw_w_taken ##2 s_axi_bvalid);
   c_unmapped: cover property (s_axi_arvalid && s_axi_arready && !mapped);
endmodule

/* File: sim/slot_sink_model.sv */
/* Stand-in for the audio interface serializer: takes one stereo pair per slot strobe.
   Assumes slot data are settled at the edge that carries the strobe. */
`timescale 1ns/1ps
module slot_sink_model #(
   parameter int unsigned WIDTH = 24
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    slot_strobe,
   input  wire logic signed [WIDTH-1:0] slot_left,
   input  wire logic signed [WIDTH-1:0] slot_right,
   output logic signed [WIDTH-1:0]      got_left,
   output logic signed [WIDTH-1:0]      got_right,
   output logic [15:0]                  frames
);
   // Data outside a strobe are never taken, so a stale pair cannot pass.
   always_ff @(posedge clk) begin
      if (srst) begin
         frames <= 16'h0000;
      end else if (slot_strobe) begin
         got_left  <= slot_left;
         got_right <= slot_right;
         frames    <= frames + 16'h0001;
      end
   end
endmodule

/* File: sim/test_adc_hpf_route_invert.sv */
/* Self-checking bench for the ADC filter, inversion and slot routing block.
   Assumes the byte addresses 0x10 and 0x38 and the 40 MHz clock. */
`timescale 1ns/1ps
module test_adc_hpf_route_invert;
   localparam int unsigned W = 24;
   localparam int DC = 32'h0010_0000;
   logic                clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                s_axi_rvalid, s_axi_rready, sample_strobe, slot_strobe, gb, gr;
   logic [31:0]         s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
   logic signed [W-1:0] adc_left, adc_right, slot_left, slot_right, got_left, got_right;
   logic signed [W-1:0] l, r;
   logic [15:0]         frames;
   int                  n_fail, cmp_count, seed;
   int                  lo[4] = '{56, 16, 1, -1};
   int                  hi[4] = '{64, 48, 6, 1};
   adc_hpf_route_invert #(.WIDTH(W)) u_adc_hpf_route_invert (
      .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sample_strobe, .adc_left, .adc_right, .slot_strobe, .slot_left, .slot_right);
   slot_sink_model #(.WIDTH(W)) u_slot_sink_model (
      .clk, .srst, .slot_strobe, .slot_left, .slot_right, .got_left, .got_right, .frames);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic conclude();
      $display("counts: %0d compared, %0d failed", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   // Ready is looked at on the falling edge, where the combinational ready has settled.
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ga, gw;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      gb = 1'b0;
      while (!gb) begin
         @(negedge clk);
         ga = s_axi_awvalid & s_axi_awready;
         gw = s_axi_wvalid & s_axi_wready;
         {gb, rsp} = {s_axi_bvalid, s_axi_bresp};
         @(posedge clk);
         if (ga) s_axi_awvalid <= 1'b0;
         if (gw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("write answered", 1, gb);
   endtask
   task automatic axi_read(input logic [31:0] a);
      logic ga;
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      gr = 1'b0;
      while (!gr) begin
         @(negedge clk);
         ga = s_axi_arvalid & s_axi_arready;
         {gr, rd, rsp} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge clk);
         if (ga) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk("read answered", 1, gr);
   endtask
   task automatic send(input logic signed [W-1:0] a, input logic signed [W-1:0] b);
      @(posedge clk);
      {adc_left, adc_right, sample_strobe} <= {a, b, 1'b1};
      @(posedge clk);
      sample_strobe <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   function automatic logic signed [W-1:0] inv(input logic signed [W-1:0] x, input logic on);
      if (!on) return x;
      if (x == {1'b1, {(W-1){1'b0}}}) return {1'b0, {(W-1){1'b1}}};
      return -x;
   endfunction
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      {adc_left, adc_right, sample_strobe} = '0;
      {n_fail, cmp_count, seed} = {32'd0, 32'd0, 32'd78120};
      srst = 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      axi_read(32'h0000_0010);
      chk("source reset", 32'h0000_4000, rd);
      axi_read(32'h0000_0038);
      chk("control reset", 32'h0000_0100, rd);
      axi_read(32'h0000_0080);
      chk("unmapped read", 32'h0000_0002, {rd[29:0], rsp});
      axi_write(32'h0000_0084, 32'h0000_ffff, 4'hf);
      chk("unmapped write", 2'b10, rsp);
      axi_write(32'h0000_0038, 32'h0000_ffff, 4'h1);
      chk("write okay", 2'b00, rsp);
      axi_read(32'h0000_0038);
      chk("control low byte", 32'h0000_0163, rd);
      $display("test registers done");
      for (int m = 0; m < 16; m++) begin
         axi_write(32'h0000_0010, {16'h0000, m[3:2], 14'h0000}, 4'hf);
         axi_write(32'h0000_0038, {30'h0, m[1:0]}, 4'hf);
         for (int k = 0; k < 2; k++) begin
            l = k == 0 ? {1'b1, {(W-1){1'b0}}} : W'($random(seed));
            r = k == 0 ? {1'b1, {(W-1){1'b0}}} : W'($random(seed));
            send(l, r);
            chk("slot left", m[3] ? inv(r, m[0]) : inv(l, m[1]), got_left);
            chk("slot right", m[2] ? inv(r, m[0]) : inv(l, m[1]), got_right);
         end
      end
      $display("test routing done");
      // The routing test leaves both slots on the right ADC, so restore the reset routing.
      axi_write(32'h0000_0010, 32'h0000_4000, 4'hf);
      // Each code starts from bypass so the filter state begins empty.
      for (int c = 0; c < 4; c++) begin
         axi_write(32'h0000_0038, 32'h0000_0000, 4'hf);
         axi_write(32'h0000_0038, 32'h0000_0102 | (c << 5), 4'hf);
         for (int k = 0; k < 24; k++) begin
            send(W'(DC), W'(DC));
            if (k == 0) chk("first left", -DC, got_left);
         end
         chk("decay", 1, 64 * got_right >= lo[c] * DC && 64 * got_right < hi[c] * DC);
      end
      chk("frames", 16'd128, frames);
      axi_read(32'h0000_0040);
      chk("status", {30'h0, got_right[W-1], got_left[W-1]}, rd);
      $display("test filter done");
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end
endmodule
bind adc_hpf_route_invert adc_hpf_monitor #(.WIDTH(WIDTH)) u_adc_hpf_monitor (
   .clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .sample_strobe, .slot_strobe, .slot_left, .slot_right);
